// file: core/mcs_burst_ctr.sv
// burst counter: loads a count and steps down once per clock
`timescale 1ns/1ps
`default_nettype none
module mcs_burst_ctr #(
	parameter int W = 8
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] load_value,
	output var  logic [W-1:0] count,
	output var  logic         nonzero
);
	import mcs_pkg::*;

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	// load wins over the decrement so a new burst never starts one short
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (load) begin
			count <= load_value;
		end else if (nonzero) begin
			count <= count - W'(1);
		end
	end

	assign nonzero = |count;

endmodule : mcs_burst_ctr
`default_nettype wire

// file: core/mcs_sequencer.sv
// maintenance command sequencer with avalon-mm register slave
// Operation
// RQ1: lock command sets busy and moves controller from 000 to 110
// RQ2: after first clock in 110, lock command sets the counter lock flag
// RQ3: manual mode locks only the console-selected processor
// RQ4: semi and auto modes lock processors named by the select field
// RQ5: a finished command clears busy and code and returns to 000
// RQ6: unlock works like lock but clears the counter lock flag
// RQ7: clear command strobes reset of designated processors' registers in 110
// RQ8: preset command strobes designated processors' registers to all ones
// RQ9: burst in manual or semi mode loads counter and enters 110
// RQ10: auto burst off slot zero waits in state 100
// RQ11: auto burst loads counter and enters 110 once slot zero is current
// RQ12: while burst count is nonzero, advance run is asserted every clock
// RQ13: burst count reaching zero clears busy and code, back to 000
// RQ14: auto burst starts at slot zero, stops after burst-count slots
// RQ15: display-to-memory walks 000, 110, 101, 111, 000; 110 sends switch
// RQ16: auto cycle advances until every designated processor finishes
// RQ17: semi cycle advances like auto but stops at slot zero
// RQ18: manual cycle advances only the console processor until it finishes
// RQ19: final display step puts display on bus and issues memory write
// RQ20: auto mode with matching slot sets the slot reserve flag
// RQ21: software writes a command only while busy is clear
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mcs_sequencer #(
	parameter int BURST_W = 8
) (
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	input  wire logic [mcs_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	output var  logic [31:0]                avs_readdata,
	output var  logic                       avs_waitrequest,
	input  wire logic [2:0]                 console_proc_sel,
	input  wire logic                       slot_zero_current,
	input  wire logic                       slot_proc_match,
	input  wire logic                       buffer_available,
	input  wire logic [mcs_pkg::NPROC-1:0]  proc_instr_done,
	output var  mcs_pkg::mcs_proc_ctl_t     proc_ctl,
	output var  mcs_pkg::mcs_mem_ctl_t      mem_ctl
);
	import mcs_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	mcs_state_t           state_reg, state_next;
	logic                 resp_reg;
	logic                 bus_wr, bus_rd_first;
	logic [31:0]          cfg_reg, switch_register, display_register;
	logic [BURST_W-1:0]   burst_field_reg, burst_count;
	logic [3:0]           cmd_code_reg;
	logic                 busy_reg;
	logic [2:0]           sel_s1, sel_s2, sel_s3, console_sel_reg;
	logic [1:0]           mode;
	logic                 auto_mode_on, slot_ok;
	logic [NPROC-1:0]     vfield, console_mask, test_mask, done_reg, pending;
	logic                 burst_load_ctl, burst_nonzero, finish;
	logic                 reserve_next, addr_x, data_x, cycle_stop;
	logic                 counter_lock_flag, proc_clear_ff, proc_preset_ff;
	logic                 slot_reserve_flag, switch_select_ff;
	logic                 addr_xfer_ff, data_xfer_ff;
	logic [31:0]          operand_bus_ff;
	logic [2:0]           state_code;
	logic                 in_six, run;

	// ----------------------------------------------------------------
	// avalon slave
	// ----------------------------------------------------------------
	// one wait state: data is prepared in the first cycle, the request is
	// accepted in the second, so a write acts only at the edge with waitrequest low
	assign avs_waitrequest = (avs_read | avs_write) & ~resp_reg;
	assign bus_wr          = avs_write & resp_reg;
	assign bus_rd_first    = avs_read & ~resp_reg;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			resp_reg <= 1'b0;
		end else begin
			resp_reg <= (avs_read | avs_write) & ~resp_reg;
		end
	end

	// read mux, unmapped offsets read as zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= DATA_RST;
		end else if (bus_rd_first) begin
			case (avs_address)
				OFS_CMD:     avs_readdata <= {23'h0, busy_reg, 4'h0, cmd_code_reg};
				OFS_CFG:     avs_readdata <= cfg_reg;
				OFS_SWITCH:  avs_readdata <= switch_register;
				OFS_DISPLAY: avs_readdata <= display_register;
				OFS_BURST:   avs_readdata <= 32'(burst_field_reg);
				OFS_STATUS:  avs_readdata <= {26'h0, slot_reserve_flag, burst_nonzero,
				                               counter_lock_flag, state_code};
				default:     avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// configuration and data registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_reg          <= CFG_RST;
			switch_register  <= DATA_RST;
			display_register <= DATA_RST;
			burst_field_reg  <= '0;
		end else if (bus_wr) begin
			case (avs_address)
				OFS_CFG:     cfg_reg          <= avs_writedata;
				OFS_SWITCH:  switch_register  <= avs_writedata;
				OFS_DISPLAY: display_register <= avs_writedata;
				OFS_BURST:   burst_field_reg  <= avs_writedata[BURST_W-1:0];
				default:     ;
			endcase
		end
	end

	// command code and busy; a write while busy is dropped so a running
	// command cannot be corrupted by an early writer
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			busy_reg     <= 1'b0;
			cmd_code_reg <= CODE_RST;
		end else if (finish) begin
			busy_reg     <= 1'b0; // RQ5
			cmd_code_reg <= CODE_RST; // RQ13
		end else if (bus_wr && avs_address == OFS_CMD && !busy_reg && state_reg == ST_IDLE
		             && avs_writedata[CMD_CODE_LSB+:4] >= CMD_DISP_MEM
		             && avs_writedata[CMD_CODE_LSB+:4] <= CMD_CYCLE) begin // RQ21
			busy_reg     <= 1'b1; // RQ1
			cmd_code_reg <= avs_writedata[CMD_CODE_LSB+:4];
		end
	end

	// ----------------------------------------------------------------
	// console switch synchroniser and mode decode
	// ----------------------------------------------------------------
	// switch value only counts once the last two stages agree
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sel_s1          <= 3'h0;
			sel_s2          <= 3'h0;
			sel_s3          <= 3'h0;
			console_sel_reg <= 3'h0;
		end else begin
			sel_s1 <= console_proc_sel;
			sel_s2 <= sel_s1;
			sel_s3 <= sel_s2;
			if (sel_s2 == sel_s3) begin
				console_sel_reg <= sel_s3;
			end
		end
	end

	assign mode         = cfg_reg[CFG_MODE_LSB+:2];
	assign vfield       = cfg_reg[CFG_VF_LSB+:NPROC];
	assign auto_mode_on = (mode == MODE_AUTO);
	assign slot_ok      = slot_proc_match & buffer_available;
	assign console_mask = NPROC'(1) << console_sel_reg;
	assign test_mask    = (mode == MODE_MANUAL) ? console_mask : vfield; // RQ3 RQ4

	// ----------------------------------------------------------------
	// controller
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_comb begin
		state_next     = state_reg;
		finish         = 1'b0;
		burst_load_ctl = 1'b0;
		reserve_next   = 1'b0;
		addr_x         = 1'b0;
		data_x         = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (busy_reg) begin
					case (cmd_code_reg)
						CMD_DISP_MEM: begin
							if (auto_mode_on && !slot_ok) begin
								state_next = ST_WAIT; // RQ15
							end else begin
								state_next   = ST_SIX;
								reserve_next = auto_mode_on; // RQ20
							end
						end
						CMD_BURST: begin
							if (auto_mode_on && !slot_zero_current) begin
								state_next = ST_WAIT; // RQ10
							end else begin
								state_next     = ST_SIX; // RQ9 RQ11
								burst_load_ctl = 1'b1;
							end
						end
						default: state_next = ST_SIX; // RQ1
					endcase
				end
			end
			ST_WAIT: begin
				if (cmd_code_reg == CMD_BURST) begin
					if (slot_zero_current) begin
						state_next     = ST_SIX; // RQ11 RQ14
						burst_load_ctl = 1'b1;
					end
				end else if (slot_ok) begin
					state_next   = ST_SIX;
					reserve_next = 1'b1; // RQ20
				end
			end
			ST_SIX: begin
				case (cmd_code_reg)
					CMD_DISP_MEM: begin
						state_next = ST_FIVE; // RQ15
						addr_x     = 1'b1;
					end
					CMD_BURST: begin
						if (!burst_nonzero) begin
							state_next = ST_IDLE; // RQ13
							finish     = 1'b1;
						end
					end
					CMD_CYCLE: begin
						if (cycle_stop) begin
							state_next = ST_IDLE; // RQ16
							finish     = 1'b1;
						end
					end
					default: begin
						state_next = ST_IDLE; // RQ5
						finish     = 1'b1;
					end
				endcase
			end
			ST_FIVE: begin
				if (!auto_mode_on || slot_ok) begin
					state_next   = ST_SEVEN; // RQ15
					reserve_next = auto_mode_on; // RQ20
				end
			end
			ST_SEVEN: begin
				state_next = ST_IDLE; // RQ19
				data_x     = 1'b1;
				finish     = 1'b1;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// documented controller code for status
	always_comb begin
		case (state_reg)
			ST_WAIT:  state_code = SC_WAIT;
			ST_SIX:   state_code = SC_SIX;
			ST_FIVE:  state_code = SC_FIVE;
			ST_SEVEN: state_code = SC_SEVEN;
			default:  state_code = SC_IDLE;
		endcase
	end

	assign in_six = (state_reg == ST_SIX);

	// ----------------------------------------------------------------
	// burst counter
	// ----------------------------------------------------------------
	mcs_burst_ctr #(
		.W (BURST_W)
	) u_burst (
		.core_clk   (core_clk),
		.rst        (rst),
		.load       (burst_load_ctl),
		.load_value (burst_field_reg),
		.count      (burst_count),
		.nonzero    (burst_nonzero)
	);

	// ----------------------------------------------------------------
	// cycle command completion tracking, one flag per processor
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NPROC; gi++) begin : g_done
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					done_reg[gi] <= 1'b0;
				end else if (state_reg == ST_IDLE && busy_reg && cmd_code_reg == CMD_CYCLE) begin
					done_reg[gi] <= 1'b0;
				end else if (in_six && cmd_code_reg == CMD_CYCLE && proc_instr_done[gi]) begin
					done_reg[gi] <= 1'b1; // RQ16
				end
			end
		end
	endgenerate

	assign pending = test_mask & ~done_reg;
	// semi mode only halts at slot zero; auto and manual halt when all are done
	assign cycle_stop = (mode == MODE_SEMI) ? (pending == '0 && slot_zero_current) // RQ17
	                                         : (pending == '0); // RQ16 RQ18

	// ----------------------------------------------------------------
	// processor controls
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			counter_lock_flag <= 1'b0;
		end else if (in_six && cmd_code_reg == CMD_LOCK) begin
			counter_lock_flag <= 1'b1; // RQ2
		end else if (in_six && cmd_code_reg == CMD_UNLOCK) begin
			counter_lock_flag <= 1'b0; // RQ6
		end
	end

	// one-clock register strobes
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			proc_clear_ff  <= 1'b0;
			proc_preset_ff <= 1'b0;
		end else begin
			proc_clear_ff  <= in_six && cmd_code_reg == CMD_CLEAR; // RQ7
			proc_preset_ff <= in_six && cmd_code_reg == CMD_PRESET; // RQ8
		end
	end

	assign run = in_six && ((cmd_code_reg == CMD_BURST && burst_nonzero) // RQ12
	             || (cmd_code_reg == CMD_CYCLE && !cycle_stop));

	always_comb begin
		proc_ctl.sel_mask      = test_mask;
		proc_ctl.lock_flag     = counter_lock_flag;
		proc_ctl.clear_strobe  = proc_clear_ff;
		proc_ctl.preset_strobe = proc_preset_ff;
		proc_ctl.advance_run   = run;
		if (mode == MODE_MANUAL) begin
			proc_ctl.adv_mask = (cmd_code_reg == CMD_CYCLE) ? pending : console_mask; // RQ18
		end else begin
			proc_ctl.adv_mask = {NPROC{1'b1}};
		end
	end

	// ----------------------------------------------------------------
	// memory path
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			switch_select_ff  <= 1'b0;
			addr_xfer_ff      <= 1'b0;
			data_xfer_ff      <= 1'b0;
			slot_reserve_flag <= 1'b0;
			operand_bus_ff    <= DATA_RST;
		end else begin
			addr_xfer_ff      <= addr_x;
			data_xfer_ff      <= data_x; // RQ19
			slot_reserve_flag <= reserve_next;
			if (addr_x) begin
				switch_select_ff <= 1'b1;
				operand_bus_ff   <= switch_register; // RQ15
			end else if (data_x) begin
				switch_select_ff <= 1'b0;
				operand_bus_ff   <= display_register; // RQ19
			end
		end
	end

	always_comb begin
		mem_ctl.operand_bus   = operand_bus_ff;
		mem_ctl.switch_select = switch_select_ff;
		mem_ctl.addr_xfer     = addr_xfer_ff;
		mem_ctl.data_xfer     = data_xfer_ff;
		mem_ctl.write_cycle   = data_xfer_ff;
		mem_ctl.slot_reserve  = slot_reserve_flag;
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_lock_start;
		@(posedge core_clk) disable iff (rst)
		(state_reg == ST_IDLE && busy_reg && cmd_code_reg == CMD_LOCK) |=> (state_code == SC_SIX && busy_reg);
	endproperty
	a_lock_start: assert property (p_lock_start) else $error("lock did not enter six"); // RQ1

	property p_lock_set;
		@(posedge core_clk) disable iff (rst)
		(in_six && cmd_code_reg == CMD_LOCK) |=> (counter_lock_flag && state_code == SC_IDLE && !busy_reg);
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock flag or finish missing"); // RQ2

	property p_manual_sel;
		@(posedge core_clk) disable iff (rst)
		(mode == MODE_MANUAL) |-> (proc_ctl.sel_mask == console_mask && $onehot(proc_ctl.sel_mask));
	endproperty
	a_manual_sel: assert property (p_manual_sel) else $error("manual select not console"); // RQ3

	property p_unlock;
		@(posedge core_clk) disable iff (rst)
		(in_six && cmd_code_reg == CMD_UNLOCK) |=> (!counter_lock_flag && cmd_code_reg == CODE_RST);
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock did not clear flag"); // RQ6

	property p_clear;
		@(posedge core_clk) disable iff (rst)
		(in_six && cmd_code_reg == CMD_CLEAR) |=> proc_ctl.clear_strobe ##1 !proc_ctl.clear_strobe;
	endproperty
	a_clear: assert property (p_clear) else $error("clear strobe not one clock"); // RQ7

	property p_burst_load;
		@(posedge core_clk) disable iff (rst)
		(state_reg == ST_IDLE && busy_reg && cmd_code_reg == CMD_BURST && !auto_mode_on)
		|=> (in_six && burst_count == $past(burst_field_reg));
	endproperty
	a_burst_load: assert property (p_burst_load) else $error("burst not loaded"); // RQ9

	property p_burst_wait;
		@(posedge core_clk) disable iff (rst)
		(state_reg == ST_IDLE && busy_reg && cmd_code_reg == CMD_BURST && auto_mode_on && !slot_zero_current)
		|=> (state_code == SC_WAIT);
	endproperty
	a_burst_wait: assert property (p_burst_wait) else $error("auto burst did not wait"); // RQ10

	property p_burst_run;
		@(posedge core_clk) disable iff (rst)
		(in_six && cmd_code_reg == CMD_BURST) |-> (proc_ctl.advance_run == burst_nonzero);
	endproperty
	a_burst_run: assert property (p_burst_run) else $error("run does not follow counter"); // RQ12

	property p_burst_end;
		@(posedge core_clk) disable iff (rst)
		(in_six && cmd_code_reg == CMD_BURST && !burst_nonzero) |=> (state_code == SC_IDLE && !busy_reg);
	endproperty
	a_burst_end: assert property (p_burst_end) else $error("burst did not finish"); // RQ13

	property p_disp_walk;
		@(posedge core_clk) disable iff (rst)
		(in_six && cmd_code_reg == CMD_DISP_MEM)
		|=> (state_code == SC_FIVE && mem_ctl.addr_xfer && mem_ctl.switch_select
		     && mem_ctl.operand_bus == switch_register);
	endproperty
	a_disp_walk: assert property (p_disp_walk) else $error("display step six wrong"); // RQ15

	property p_disp_write;
		@(posedge core_clk) disable iff (rst)
		(state_reg == ST_SEVEN) |=> (mem_ctl.write_cycle && !mem_ctl.switch_select && state_code == SC_IDLE);
	endproperty
	a_disp_write: assert property (p_disp_write) else $error("display write missing"); // RQ19

endmodule : mcs_sequencer
`default_nettype wire

// file: inc/mcs_pkg.sv
// shared constants and types of the maintenance command sequencer
`default_nettype none
package mcs_pkg;

	// ----------------------------------------------------------------
	// register map (byte offsets on the avalon slave)
	// ----------------------------------------------------------------
	localparam int          ADDR_W       = 5;
	localparam logic [4:0]  OFS_CMD      = 5'h00;
	localparam logic [4:0]  OFS_CFG      = 5'h04;
	localparam logic [4:0]  OFS_SWITCH   = 5'h08;
	localparam logic [4:0]  OFS_DISPLAY  = 5'h0c;
	localparam logic [4:0]  OFS_BURST    = 5'h10;
	localparam logic [4:0]  OFS_STATUS   = 5'h14;

	// field positions
	localparam int          CMD_CODE_LSB = 0;
	localparam int          CMD_BUSY_BIT = 8;
	localparam int          CFG_MODE_LSB = 0;
	localparam int          CFG_VF_LSB   = 8;
	localparam int          ST_CODE_LSB  = 0;
	localparam int          ST_LOCK_BIT  = 3;
	localparam int          ST_RUN_BIT   = 4;
	localparam int          ST_RSV_BIT   = 5;

	// values after reset
	localparam logic [31:0] CFG_RST      = 32'h0000_0000;
	localparam logic [31:0] DATA_RST     = 32'h0000_0000;
	localparam logic [3:0]  CODE_RST     = 4'h0;

	// ----------------------------------------------------------------
	// commands, modes, controller states
	// ----------------------------------------------------------------
	localparam int          NPROC        = 8;
	localparam logic [3:0]  CMD_DISP_MEM = 4'h7;
	localparam logic [3:0]  CMD_LOCK     = 4'h8;
	localparam logic [3:0]  CMD_UNLOCK   = 4'h9;
	localparam logic [3:0]  CMD_CLEAR    = 4'ha;
	localparam logic [3:0]  CMD_PRESET   = 4'hb;
	localparam logic [3:0]  CMD_BURST    = 4'hc;
	localparam logic [3:0]  CMD_CYCLE    = 4'hd;

	localparam logic [1:0]  MODE_MANUAL  = 2'h0;
	localparam logic [1:0]  MODE_SEMI    = 2'h1;
	localparam logic [1:0]  MODE_AUTO    = 2'h2;

	// three-bit controller codes shown in status
	localparam logic [2:0]  SC_IDLE      = 3'h0;
	localparam logic [2:0]  SC_WAIT      = 3'h4;
	localparam logic [2:0]  SC_SIX       = 3'h6;
	localparam logic [2:0]  SC_FIVE      = 3'h5;
	localparam logic [2:0]  SC_SEVEN     = 3'h7;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_WAIT  = 5'h02,
		ST_SIX   = 5'h04,
		ST_FIVE  = 5'h08,
		ST_SEVEN = 5'h10
	} mcs_state_t;

	// per-processor controls toward the processor array
	typedef struct packed {
		logic [NPROC-1:0] sel_mask;
		logic [NPROC-1:0] adv_mask;
		logic             lock_flag;
		logic             clear_strobe;
		logic             preset_strobe;
		logic             advance_run;
	} mcs_proc_ctl_t;

	// memory path controls
	typedef struct packed {
		logic [31:0] operand_bus;
		logic        switch_select;
		logic        addr_xfer;
		logic        data_xfer;
		logic        write_cycle;
		logic        slot_reserve;
	} mcs_mem_ctl_t;

endpackage : mcs_pkg
`default_nettype wire

// file: verif/mcs_far_model.sv
// far-side model: time slot table and processor array
`timescale 1ns/1ps
`default_nettype none
module mcs_far_model (
	input  wire logic                      core_clk,
	input  wire logic                      rst,
	input  wire logic                      hold,
	input  wire mcs_pkg::mcs_proc_ctl_t    proc_ctl,
	output var  logic                      slot_zero_current,
	output var  logic                      slot_proc_match,
	output var  logic                      buffer_available,
	output var  logic [mcs_pkg::NPROC-1:0] proc_instr_done
);
	import mcs_pkg::*;
	logic [2:0] slot_reg;
	// ----------------------------------------------------------------
	// slots and processors
	// ----------------------------------------------------------------
	// hold parks the table on a nonzero slot so the wait state is seen
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			slot_reg <= 3'h2;
		end else if (hold) begin
			slot_reg <= 3'h2;
		end else begin
			slot_reg <= slot_reg + 3'h1;
		end
	end
	// match and buffer differ, so both must be high together
	assign slot_zero_current = (slot_reg == 3'h0);
	assign slot_proc_match   = (slot_reg == 3'h3);
	assign buffer_available  = slot_reg[0];
	// an advanced processor completes its instruction one clock later
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			proc_instr_done <= '0;
		end else begin
			proc_instr_done <= proc_ctl.adv_mask & {NPROC{proc_ctl.advance_run}};
		end
	end
endmodule : mcs_far_model
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench of the maintenance command sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import mcs_pkg::*;
	logic              core_clk = 1'b0;
	logic              rst = 1'b1;
	logic [ADDR_W-1:0] avs_address = '0;
	logic              avs_read = 1'b0;
	logic              avs_write = 1'b0;
	logic [31:0]       avs_writedata = '0;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	logic [2:0]        console_proc_sel = 3'h5;
	logic              hold = 1'b0;
	logic              sz, spm, ba;
	logic [NPROC-1:0]  done;
	mcs_proc_ctl_t     pc;
	mcs_mem_ctl_t      mc;
	int                err_total = 0;
	int                num_checks = 0;
	int                n_run, n_clr, n_pre, n_ax, n_dx, n_rsv;
	logic [31:0]       op_a, op_d, q;
	// cmd, mode, select field, lock after, expected select mask
	logic [27:0] rows [6] = '{28'h8_0_a5_1_20, 28'h9_0_a5_0_04, 28'h8_1_a5_1_a5,
		28'ha_2_3c_1_3c, 28'hb_1_0f_1_0f, 28'h9_2_81_0_81};
	// ----------------------------------------------------------------
	// clock, design, far side
	// ----------------------------------------------------------------
	always #50 core_clk = ~core_clk;
	mcs_sequencer #(.BURST_W(8)) mcs_sequencer_inst (.core_clk(core_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.console_proc_sel(console_proc_sel), .slot_zero_current(sz), .slot_proc_match(spm),
		.buffer_available(ba), .proc_instr_done(done), .proc_ctl(pc), .mem_ctl(mc));
	mcs_far_model mcs_far_model_inst (.core_clk(core_clk), .rst(rst), .hold(hold), .proc_ctl(pc),
		.slot_zero_current(sz), .slot_proc_match(spm), .buffer_available(ba), .proc_instr_done(done));
	// counts pulses so one-cycle strobes are never missed between polls
	always @(posedge core_clk) begin
		n_run += pc.advance_run;
		n_clr += pc.clear_strobe;
		n_pre += pc.preset_strobe;
		n_rsv += mc.slot_reserve;
		n_ax += mc.addr_xfer;
		n_dx += mc.data_xfer & mc.write_cycle;
		if (mc.addr_xfer & mc.switch_select) op_a = mc.operand_bus;
		if (mc.data_xfer) op_d = mc.operand_bus;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, s);
			err_total++;
		end
	endtask : chk
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up
	// one avalon transfer, held until waitrequest is seen low
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			err_total++;
			wrap_up();
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask : bus
	// software must see busy clear before the next command
	task poll;
		int n;
		n = 0;
		do begin
			bus(1'b0, OFS_CMD, 32'h0);
			n++;
		end while (q[CMD_BUSY_BIT] !== 1'b0 && n < 120);
		if (n >= 120) begin
			err_total++;
			wrap_up();
		end
		chk("code", 32'h0, q);
	endtask : poll
	task run(input logic [3:0] c);
		bus(1'b1, OFS_CMD, {28'h0, c});
		poll();
	endtask : run
	task zero;
		@(negedge core_clk);
		{n_run, n_clr, n_pre, n_rsv, n_ax, n_dx} = '0;
		@(posedge core_clk);
	endtask : zero
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk("status_rst", 32'h0, q);
		bus(1'b0, OFS_CFG, 32'h0);
		chk("cfg_rst", CFG_RST, q);
		bus(1'b0, 5'h18, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("test reset done");
		foreach (rows[i]) begin
			if (i == 1) console_proc_sel <= 3'h2;
			bus(1'b1, OFS_CFG, {16'h0, rows[i][19:12], 6'h0, rows[i][21:20]});
			zero();
			run(rows[i][27:24]);
			bus(1'b0, OFS_STATUS, 32'h0);
			chk("lock", rows[i][8], q[ST_LOCK_BIT]);
			chk("lock_pin", rows[i][8], pc.lock_flag);
			chk("sel", rows[i][7:0], pc.sel_mask);
			chk("clr", rows[i][27:24] == CMD_CLEAR, n_clr);
			chk("pre", rows[i][27:24] == CMD_PRESET, n_pre);
		end
		$display("test table done");
		for (int m = 0; m < 2; m++) begin
			bus(1'b1, OFS_CFG, m);
			bus(1'b1, OFS_BURST, 5 - 4 * m);
			zero();
			run(CMD_BURST);
			chk("burst_run", 5 - 4 * m, n_run);
		end
		bus(1'b1, OFS_CFG, {30'h0, MODE_AUTO});
		bus(1'b1, OFS_BURST, 32'h7);
		hold <= 1'b1;
		zero();
		bus(1'b1, OFS_CMD, {28'h0, CMD_BURST});
		bus(1'b0, OFS_STATUS, 32'h0);
		chk("wait_code", SC_WAIT, q[2:0]);
		chk("wait_run", 32'h0, n_run);
		hold <= 1'b0;
		poll();
		chk("auto_run", 32'h7, n_run);
		$display("test burst done");
		bus(1'b1, OFS_CFG, 32'h0);
		bus(1'b1, OFS_BURST, 32'h3c);
		bus(1'b1, OFS_CMD, {28'h0, CMD_BURST});
		bus(1'b1, OFS_CMD, {28'h0, CMD_LOCK});
		poll();
		bus(1'b0, OFS_STATUS, 32'h0);
		chk("busy_write", 32'h0, q[ST_LOCK_BIT]);
		bus(1'b1, OFS_CMD, 32'h3);
		bus(1'b0, OFS_CMD, 32'h0);
		chk("bad_code", 32'h0, q);
		$display("test refusal done");
		bus(1'b1, OFS_SWITCH, 32'h1234_abcd);
		bus(1'b1, OFS_DISPLAY, 32'h5a5a_0f0f);
		for (int m = 0; m < 3; m += 2) begin
			bus(1'b1, OFS_CFG, 32'h0800 | m);
			zero();
			run(CMD_DISP_MEM);
			chk("addr_xfer", 32'h1, n_ax);
			chk("data_xfer", 32'h1, n_dx);
			chk("op_addr", 32'h1234_abcd, op_a);
			chk("op_data", 32'h5a5a_0f0f, op_d);
			chk("reserve", m, n_rsv);
		end
		$display("test display done");
		for (int m = 0; m < 3; m++) begin
			bus(1'b1, OFS_CFG, 32'h0300 | m);
			zero();
			run(CMD_CYCLE);
			chk("cycle_run", 32'h1, n_run > 0);
		end
		$display("test cycle done");
		wrap_up();
	end
	// a hang is cut short and reported as a mismatch
	initial begin
		repeat (50000) @(posedge core_clk);
		err_total++;
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
